// file: rps_far_model.sv
// Purpose: far side of the reset block: clear pin, supply sensors, oscillators
// Assumes: the bench moves the control levels just after pclk edges
// Notes: both oscillators run free, neither is a framed link
`timescale 1ns/1ps
module rps_far_model (
  input  wire logic clr_req,
  input  wire logic sup_up,
  input  wire logic brn_low,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_n,
  output logic      supply_rise_det,
  output logic      brownout_det,
  output logic      rcosc_clk,
  output logic      clock_input_pin
);
  // pulled up; the button or the block itself may pull the wire low
  assign pin_n = !(clr_req || (pin_oe && !pin_o));
  assign supply_rise_det = sup_up;
  assign brownout_det    = brn_low;
  // rc period 660 ns, unrelated to pclk
  initial begin
    rcosc_clk = 1'b0;
    forever #330 rcosc_clk = !rcosc_clk;
  end
  // crystal period 70 ns, runs whether or not it is used
  initial begin
    clock_input_pin = 1'b0;
    forever #35 clock_input_pin = !clock_input_pin;
  end
endmodule

// file: rps_pkg.sv
// Purpose: shared constants for the reset source and power-up timer block
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes: config reset value mirrors an unprogrammed part
package rps_pkg;
  // register byte offsets
  localparam int unsigned APB_AW    = 4;
  localparam logic [3:0]  ADDR_CFG  = 4'h0;
  localparam logic [3:0]  ADDR_STAT = 4'h4;
  localparam logic [3:0]  ADDR_ISR  = 4'h8;
  localparam logic [3:0]  ADDR_IMR  = 4'hc;

  // cfg fields
  localparam int unsigned CFG_OSC_LO  = 0;
  localparam int unsigned CFG_OSC_HI  = 1;
  localparam int unsigned CFG_PUD_EN  = 2;
  localparam int unsigned CFG_BRN_EN  = 3;
  localparam int unsigned CFG_EXT_CLK = 4;
  localparam int unsigned CFG_W       = 5;
  // rc mode, delay off, brown-out on, resonator fitted
  localparam logic [CFG_W-1:0] CFG_RST = 5'h0b;

  // stat fields
  localparam int unsigned STAT_TMO    = 0;
  localparam int unsigned STAT_PWD    = 1;
  localparam int unsigned STAT_CAU_LO = 2;
  localparam int unsigned STAT_CAU_HI = 4;
  localparam int unsigned STAT_RST    = 5;
  localparam int unsigned STAT_PUD    = 6;
  localparam int unsigned STAT_OSU    = 7;
  localparam logic        FLAG_RST    = 1'h1;

  // synchronised pin vector
  localparam int unsigned PIN_MCN = 0;
  localparam int unsigned PIN_SUP = 1;
  localparam int unsigned PIN_BRN = 2;
  localparam int unsigned PIN_RCO = 3;
  localparam int unsigned PIN_CLK = 4;
  localparam int unsigned NPIN    = 5;
  localparam logic [NPIN-1:0] PIN_RST = 5'h01; // clear pin idles high

  // timing
  localparam int unsigned PUD_TIME_MS     = 72;
  localparam int unsigned RCOSC_KHZ       = 100; // nominal, plain default
  localparam int unsigned OSU_CYCLES      = 1024;
  localparam int unsigned FILT_CYCLES_DEF = 8;

  typedef enum logic [1:0] {
    low_power_crystal_mode  = 2'h0,
    crystal_resonator_mode  = 2'h1,
    high_speed_crystal_mode = 2'h2,
    resistor_capacitor_mode = 2'h3
  } rps_osc_t;

  localparam int unsigned NCAUSE = 7;
  typedef enum logic [2:0] {
    cause_por        = 3'h0,
    cause_mrst_run   = 3'h1,
    cause_mrst_sleep = 3'h2,
    cause_wdog_rst   = 3'h3,
    cause_wdog_wake  = 3'h4,
    cause_brown      = 3'h5,
    cause_int_wake   = 3'h6
  } rps_cause_t;

  // gray along hold -> delay -> start-up -> run
  typedef enum logic [1:0] {
    st_run  = 2'h0,
    st_hold = 2'h1,
    st_pud  = 2'h3,
    st_osu  = 2'h2
  } rps_state_t;
endpackage

// file: rps_reset_ctl.sv
// Purpose: reset cause decode, power-up delay, oscillator start-up count
// Assumes: pins asynchronous to pclk; watchdog and sleep strobes on pclk
// Notes: delay ticks on the on-chip rc oscillator, start-up on clock input
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module rps_reset_ctl #(
  parameter int unsigned PUD_TICKS   = rps_pkg::PUD_TIME_MS * rps_pkg::RCOSC_KHZ,
  parameter int unsigned FILT_CYCLES = rps_pkg::FILT_CYCLES_DEF,
  parameter int unsigned TW          = 16
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [rps_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      master_clear_pin_n,
  output logic                           master_clear_pin_o,
  output logic                           master_clear_pin_oe,
  input  wire logic                      supply_rise_det,
  input  wire logic                      brownout_det,
  input  wire logic                      rcosc_clk,
  input  wire logic                      clock_input_pin,
  input  wire logic                      watchdog_timeout,
  input  wire logic                      sleep_state,
  input  wire logic                      int_wake,
  output logic                           chip_reset,
  output logic                           regs_reset,
  output logic                           wake_resume,
  output logic      [1:0]                osc_mode_select,
  output logic                           osc_amp_en,
  output logic                           irq
);
  localparam int unsigned FW = $clog2(FILT_CYCLES + 1);
  localparam logic [FW-1:0] FILT_LAST = FW'(FILT_CYCLES - 1);

  rps_tmr_if #(.W(TW)) pud ();
  rps_tmr_if #(.W(TW)) osu ();

  logic [rps_pkg::NPIN-1:0]   pin_s1;
  logic [rps_pkg::NPIN-1:0]   pin_s2;
  logic [rps_pkg::NPIN-1:0]   pin_d3;
  logic [FW-1:0]              filt_cnt;
  logic                       mrst_low;
  logic                       mrst_fall;
  logic [rps_pkg::CFG_W-1:0]  cfg;
  logic [rps_pkg::NCAUSE-1:0] isr;
  logic [rps_pkg::NCAUSE-1:0] imr;
  rps_pkg::rps_state_t        state;
  rps_pkg::rps_state_t        next_state;
  rps_pkg::rps_cause_t        cause;
  rps_pkg::rps_cause_t        cause_in;
  logic                       ev_ok;
  logic                       is_wake;
  logic                       need_pud;
  logic                       next_need_pud;
  logic                       need_osu;
  logic                       next_need_osu;
  logic                       defd;
  logic                       next_defd;
  logic                       timeout_flag;
  logic                       powerdown_flag;
  logic                       por_ev;
  logic                       brn_ev;
  logic                       xtal;
  logic                       pud_on;
  logic                       hold_on;
  logic                       wr_acc;
  logic [rps_pkg::NCAUSE-1:0] ev_vec;
  logic [rps_pkg::NCAUSE-1:0] w1c;

  // two flops on every pin; the third only feeds edge detectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= rps_pkg::PIN_RST;
      pin_s2 <= rps_pkg::PIN_RST;
      pin_d3 <= rps_pkg::PIN_RST;
    end else if (clk_en) begin
      pin_s1 <= {clock_input_pin, rcosc_clk, brownout_det,
                 supply_rise_det, master_clear_pin_n};
      pin_s2 <= pin_s1;
      pin_d3 <= pin_s2;
    end
  end

  // clear pin filter: level must hold FILT_CYCLES samples to count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_cnt  <= '0;
      mrst_low  <= 1'h0;
      mrst_fall <= 1'h0;
    end else if (clk_en) begin
      mrst_fall <= 1'h0;
      if (pin_s2[rps_pkg::PIN_MCN] != mrst_low) begin
        filt_cnt <= '0;
      end else if (filt_cnt == FILT_LAST) begin
        filt_cnt  <= '0;
        mrst_low  <= !mrst_low;
        mrst_fall <= !mrst_low;
      end else begin
        filt_cnt <= filt_cnt + FW'(1);
      end
    end
  end

  // rising supply edge is the power-on pulse
  assign por_ev  = pin_s2[rps_pkg::PIN_SUP] & ~pin_d3[rps_pkg::PIN_SUP];
  assign brn_ev  = cfg[rps_pkg::CFG_BRN_EN] & pin_s2[rps_pkg::PIN_BRN]
                   & ~pin_d3[rps_pkg::PIN_BRN];
  assign xtal    = cfg[rps_pkg::CFG_OSC_HI:rps_pkg::CFG_OSC_LO]
                   != rps_pkg::resistor_capacitor_mode;
  assign pud_on  = cfg[rps_pkg::CFG_PUD_EN] | cfg[rps_pkg::CFG_BRN_EN];
  assign hold_on = mrst_low | (cfg[rps_pkg::CFG_BRN_EN] & pin_s2[rps_pkg::PIN_BRN]);

  // cause priority: power-on, brown-out, clear, watchdog, wake
  always_comb begin
    ev_ok    = 1'h1;
    cause_in = cause;
    if (por_ev) begin
      cause_in = rps_pkg::cause_por;
    end else if (brn_ev) begin
      cause_in = rps_pkg::cause_brown;
    end else if (state == rps_pkg::st_run && mrst_fall) begin
      cause_in = sleep_state ? rps_pkg::cause_mrst_sleep : rps_pkg::cause_mrst_run;
    end else if (state == rps_pkg::st_run && watchdog_timeout) begin
      cause_in = sleep_state ? rps_pkg::cause_wdog_wake : rps_pkg::cause_wdog_rst;
    end else if (state == rps_pkg::st_run && int_wake && sleep_state) begin
      cause_in = rps_pkg::cause_int_wake;
    end else begin
      ev_ok = 1'h0;
    end
  end

  assign is_wake = cause_in == rps_pkg::cause_wdog_wake
                   || cause_in == rps_pkg::cause_int_wake;

  // sequencer next state; wake skips the hold and the register reset, chip reset stays on through a crystal start-up
  always_comb begin
    next_state    = state;
    next_need_pud = need_pud;
    next_need_osu = need_osu;
    next_defd     = defd;
    if (ev_ok) begin
      next_defd     = !is_wake;
      next_need_pud = cause_in == rps_pkg::cause_por
                      || cause_in == rps_pkg::cause_brown;
      next_need_osu = cause_in == rps_pkg::cause_por || is_wake;
      if (is_wake) begin
        next_state = xtal ? rps_pkg::st_osu : rps_pkg::st_run;
      end else begin
        next_state = rps_pkg::st_hold;
      end
    end else begin
      unique case (state)
        rps_pkg::st_run: begin
          next_state = rps_pkg::st_run;
        end
        rps_pkg::st_hold: begin
          if (!hold_on) begin
            if (need_pud && pud_on) begin
              next_state = rps_pkg::st_pud;
            end else if (need_osu && xtal) begin
              next_state = rps_pkg::st_osu;
            end else begin
              next_state = rps_pkg::st_run;
            end
          end
        end
        rps_pkg::st_pud: begin
          if (pud.done) begin
            next_state = (need_osu && xtal) ? rps_pkg::st_osu : rps_pkg::st_run;
          end
        end
        rps_pkg::st_osu: begin
          if (osu.done) begin
            next_state = rps_pkg::st_run;
          end
        end
      endcase
    end
  end

  // sequencer registers and reset outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= rps_pkg::st_hold;
      need_pud    <= 1'h1;
      need_osu    <= 1'h1;
      defd        <= 1'h1;
      chip_reset  <= 1'h1;
      regs_reset  <= 1'h1;
      wake_resume <= 1'h0;
    end else if (clk_en) begin
      state       <= next_state;
      need_pud    <= next_need_pud;
      need_osu    <= next_need_osu;
      defd        <= next_defd;
      chip_reset  <= (next_state != rps_pkg::st_run) | mrst_low;
      // reset-independent storage sees only presetn, never this
      regs_reset  <= (next_state != rps_pkg::st_run) & next_defd;
      wake_resume <= !next_defd && next_state == rps_pkg::st_run
                     && (state != rps_pkg::st_run || ev_ok);
    end
  end

  // delay counts rc oscillator edges, start-up counts clock input edges
  assign pud.start = next_state == rps_pkg::st_pud && state != rps_pkg::st_pud;
  assign pud.tick  = pin_s2[rps_pkg::PIN_RCO] & ~pin_d3[rps_pkg::PIN_RCO];
  assign pud.limit = TW'(PUD_TICKS);
  assign osu.start = next_state == rps_pkg::st_osu && state != rps_pkg::st_osu;
  assign osu.tick  = pin_s2[rps_pkg::PIN_CLK] & ~pin_d3[rps_pkg::PIN_CLK];
  assign osu.limit = TW'(rps_pkg::OSU_CYCLES);

  rps_tmr #(.W(TW)) u_pud (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .tmr     (pud)
  );

  rps_tmr #(.W(TW)) u_osu (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .tmr     (osu)
  );

  // cause and flag record for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause          <= rps_pkg::cause_por;
      timeout_flag   <= rps_pkg::FLAG_RST;
      powerdown_flag <= rps_pkg::FLAG_RST;
    end else if (clk_en && ev_ok) begin
      cause <= cause_in;
      unique case (cause_in)
        rps_pkg::cause_por, rps_pkg::cause_brown: begin
          timeout_flag   <= 1'h1;
          powerdown_flag <= 1'h1;
        end
        rps_pkg::cause_mrst_run: begin
          timeout_flag <= timeout_flag; // left as it was
        end
        rps_pkg::cause_mrst_sleep, rps_pkg::cause_int_wake: begin
          timeout_flag   <= 1'h1;
          powerdown_flag <= 1'h0;
        end
        rps_pkg::cause_wdog_rst: begin
          timeout_flag <= 1'h0;
        end
        rps_pkg::cause_wdog_wake: begin
          timeout_flag   <= 1'h0;
          powerdown_flag <= 1'h0;
        end
        default: begin
          timeout_flag <= timeout_flag; // unused code
        end
      endcase
    end
  end

  // apb: zero wait states, misaligned address answers with an error
  assign pready  = 1'h1;
  assign pslverr = psel & penable & (paddr[1:0] != 2'h0);
  assign wr_acc  = psel & penable & pwrite & (paddr[1:0] == 2'h0);
  assign ev_vec  = ev_ok ? rps_pkg::NCAUSE'(7'h01 << cause_in) : '0;
  assign w1c     = (wr_acc && paddr == rps_pkg::ADDR_ISR)
                   ? pwdata[rps_pkg::NCAUSE-1:0] : '0;

  // config, mask, sticky causes; a new cause wins over its own clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= rps_pkg::CFG_RST;
      imr <= '0;
      isr <= '0;
    end else if (clk_en) begin
      isr <= (isr & ~w1c) | ev_vec;
      if (wr_acc && paddr == rps_pkg::ADDR_CFG) begin
        cfg <= pwdata[rps_pkg::CFG_W-1:0];
      end
      if (wr_acc && paddr == rps_pkg::ADDR_IMR) begin
        imr <= pwdata[rps_pkg::NCAUSE-1:0];
      end
    end
  end

  // read data captured in the setup phase, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (clk_en && psel && !penable) begin
      unique case (paddr)
        rps_pkg::ADDR_CFG:  prdata <= 32'(cfg);
        rps_pkg::ADDR_STAT: prdata <= 32'({osu.busy, pud.busy, chip_reset,
                                          cause, powerdown_flag, timeout_flag});
        rps_pkg::ADDR_ISR:  prdata <= 32'(isr);
        rps_pkg::ADDR_IMR:  prdata <= 32'(imr);
        default:            prdata <= '0;
      endcase
    end
  end

  // oscillator outputs and irq; amplifier off when an outside clock drives the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_mode_select <= rps_pkg::CFG_RST[rps_pkg::CFG_OSC_HI:rps_pkg::CFG_OSC_LO];
      osc_amp_en      <= 1'h0;
      irq             <= 1'h0;
    end else if (clk_en) begin
      osc_mode_select <= cfg[rps_pkg::CFG_OSC_HI:rps_pkg::CFG_OSC_LO];
      osc_amp_en      <= xtal & ~cfg[rps_pkg::CFG_EXT_CLK];
      irq             <= |(isr & imr);
    end
  end

  // the clear pin is input only: no reset cause ever pulls it
  assign master_clear_pin_o  = 1'h0;
  assign master_clear_pin_oe = 1'h0;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  sequence s_wake;
    ev_ok && is_wake;
  endsequence

  sequence s_por_hold;
    ev_ok && cause_in == rps_pkg::cause_por ##1 state == rps_pkg::st_hold;
  endsequence

  AST_WAKE_KEEP: assert property (s_wake |=> !regs_reset [*2])
    else $error("wake-up applied a register reset");
  AST_POR_FLAGS: assert property (s_por_hold |-> timeout_flag && powerdown_flag)
    else $error("power-on did not set both flags");
  AST_WDOG_RST: assert property (ev_ok && cause_in == rps_pkg::cause_wdog_rst
    |=> !timeout_flag && powerdown_flag == $past(powerdown_flag) && regs_reset)
    else $error("watchdog reset flags or reset wrong");
  AST_WDOG_PIN: assert property (watchdog_timeout |-> !master_clear_pin_oe [*3])
    else $error("clear pin driven after watchdog");
  AST_PUD_HOLD: assert property (state == rps_pkg::st_pud |-> chip_reset)
    else $error("chip released during power-up delay");
  AST_PUD_FORCE: assert property (state == rps_pkg::st_hold && !hold_on && !ev_ok
    && need_pud && cfg[rps_pkg::CFG_BRN_EN] |=> state == rps_pkg::st_pud)
    else $error("brown-out enable did not force the delay");
  AST_PUD_ONLY: assert property ($rose(pud.busy) |-> need_pud)
    else $error("power-up delay started without power-on");
  AST_OSU_XTAL: assert property ($rose(osu.busy) |-> xtal && need_osu)
    else $error("start-up count in rc mode or wrong cause");
  AST_OSU_END: assert property (state == rps_pkg::st_osu && osu.done && !ev_ok
    |=> state == rps_pkg::st_run ##1 !chip_reset || mrst_low)
    else $error("reset not released after start-up count");
  AST_FILT: assert property ($changed(mrst_low) |-> $past(filt_cnt) == FILT_LAST)
    else $error("clear filter switched early");
endmodule

// file: rps_tmr.sv
// Purpose: down counter of tick pulses with busy level and done pulse
// Assumes: start and tick come from logic on pclk
// Notes: a start while busy reloads the count
`timescale 1ns/1ps
module rps_tmr #(
  parameter int unsigned W = 16
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  rps_tmr_if.timer  tmr
);
  logic [W-1:0] cnt;

  // reload on start, count ticks, pulse done on the last one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= '0;
      tmr.busy <= 1'h0;
      tmr.done <= 1'h0;
    end else if (clk_en) begin
      tmr.done <= 1'h0;
      if (tmr.start) begin
        cnt      <= tmr.limit;
        tmr.busy <= 1'h1;
      end else if (tmr.busy && tmr.tick) begin
        cnt <= cnt - W'(1);
        if (cnt <= W'(1)) begin
          tmr.busy <= 1'h0;
          tmr.done <= 1'h1;
        end
      end
    end
  end
endmodule

// file: rps_tmr_if.sv
// Purpose: start/tick/done bundle between sequencer and a down counter
// Assumes: all signals on pclk
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
interface rps_tmr_if #(parameter int unsigned W = 16);
  logic         start;
  logic         tick;
  logic [W-1:0] limit;
  logic         busy;
  logic         done;
  modport owner (output start, output tick, output limit, input busy, input done);
  modport timer (input start, input tick, input limit, output busy, output done);
endinterface

// file: test_reset_source_and_powerup_timer.sv
// Purpose: self-checking bench for the reset source and power-up timer block
// Assumes: delay shortened to 20 rc edges, clear filter of 4 samples
// Notes: read results are matched against a queue of notes by a monitor
`timescale 1ns/1ps
module test_reset_source_and_powerup_timer;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [3:0]  paddr;
  logic [31:0] pwdata, prdata, q_exp[$];
  logic        master_clear_pin_n, master_clear_pin_o, master_clear_pin_oe;
  logic        supply_rise_det, brownout_det, rcosc_clk, clock_input_pin;
  logic        watchdog_timeout, sleep_state, int_wake, chip_reset, regs_reset;
  logic        wake_resume, osc_amp_en, irq, clr_req, sup_up, brn_low;
  logic [1:0]  osc_mode_select;
  logic [15:0] lf;
  int          fails, n_checks, n;

  rps_reset_ctl #(.PUD_TICKS(20), .FILT_CYCLES(4)) rps_reset_ctl_inst (
    .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .master_clear_pin_n, .master_clear_pin_o,
    .master_clear_pin_oe, .supply_rise_det, .brownout_det, .rcosc_clk,
    .clock_input_pin, .watchdog_timeout, .sleep_state, .int_wake, .chip_reset,
    .regs_reset, .wake_resume, .osc_mode_select, .osc_amp_en, .irq);
  rps_far_model rps_far_model_inst (.clr_req, .sup_up, .brn_low,
    .pin_o(master_clear_pin_o), .pin_oe(master_clear_pin_oe),
    .pin_n(master_clear_pin_n), .supply_rise_det, .brownout_det, .rcosc_clk,
    .clock_input_pin);

  // 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = !pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic timeout();
    fails++;
    $display("wrong value at %0t: wait ran out", $time);
    final_report();
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) timeout();
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q_exp.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // wait for the chip to leave reset, counting cycles
  task automatic wlow(output int c);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
    end while (chip_reset !== 1'b0 && c < 20000);
    if (chip_reset !== 1'b0) timeout();
  endtask

  task automatic wd_pulse(input logic slp);
    @(posedge pclk);
    sleep_state <= slp;
    watchdog_timeout <= 1'b1;
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
  endtask

  task automatic clr(input int c);
    @(posedge pclk);
    clr_req <= 1'b1;
    repeat (c) @(posedge pclk);
    clr_req <= 1'b0;
  endtask

  // bit 0: wake pulse seen, bit 1: register reset seen
  task automatic ww(output int r);
    r = 0;
    repeat (10) begin
      @(negedge pclk);
      if (wake_resume === 1'b1) r |= 1;
      if (regs_reset !== 1'b0) r |= 2;
    end
  endtask

  function automatic logic [31:0] st(input logic [2:0] c, input logic pwd, input logic tmo);
    return {24'h0, 3'h0, c, pwd, tmo};
  endfunction

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // results appear at the access edge; oldest note is the expectation
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (q_exp.size() == 0) chk(prdata, 32'hffffffff);
      else chk(prdata, q_exp.pop_front());
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {watchdog_timeout, sleep_state, int_wake, clr_req, sup_up, brn_low} = '0;
    fails = 0;
    n_checks = 0;
    lf = 16'h000a;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    sup_up <= 1'b1;
    repeat (15) @(posedge pclk);
    presetn <= 1'b1;
    wlow(n);
    chk(32'(n >= 520), 32'h1);
    chk(32'(osc_mode_select), 32'h3);
    rd(rps_pkg::ADDR_STAT, st(rps_pkg::cause_por, 1'b1, 1'b1));
    wr(rps_pkg::ADDR_ISR, 32'h7f);
    rd(rps_pkg::ADDR_ISR, 32'h0);
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      wr(rps_pkg::ADDR_IMR, {16'h0, lf});
      rd(rps_pkg::ADDR_IMR, {25'h0, lf[6:0]});
    end
    for (int m = 0; m < 8; m++) begin
      wr(rps_pkg::ADDR_CFG, {27'h0, m[2], 2'b10, m[1:0]});
      repeat (2) @(negedge pclk);
      chk(32'(osc_mode_select), 32'(m[1:0]));
      chk(32'(osc_amp_en), 32'(m[1:0] != 2'h3 && !m[2]));
    end
    wr(rps_pkg::ADDR_CFG, 32'h0b);
    $display("end of test: power-on and modes");
    wr(rps_pkg::ADDR_IMR, 32'h08);
    wd_pulse(1'b0);
    @(negedge pclk);
    // the pin output and its enable must both stay low after a watchdog reset
    chk(32'({chip_reset, regs_reset, master_clear_pin_oe, master_clear_pin_o}), 32'hc);
    wlow(n);
    rd(rps_pkg::ADDR_STAT, st(rps_pkg::cause_wdog_rst, 1'b1, 1'b0));
    chk(32'(irq), 32'h1);
    wr(rps_pkg::ADDR_ISR, 32'h08);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h0);
    $display("end of test: watchdog reset");
    clr(2);
    repeat (30) @(negedge pclk);
    chk(32'(chip_reset), 32'h0);
    rd(rps_pkg::ADDR_ISR, 32'h0);
    clr(20);
    wlow(n);
    rd(rps_pkg::ADDR_STAT, st(rps_pkg::cause_mrst_run, 1'b1, 1'b0));
    rd(rps_pkg::ADDR_ISR, 32'h02);
    chk(32'(irq), 32'h0);
    $display("end of test: clear pin");
    wd_pulse(1'b1);
    ww(n);
    chk(32'(n), 32'h1);
    rd(rps_pkg::ADDR_STAT, st(rps_pkg::cause_wdog_wake, 1'b0, 1'b0));
    clr(20);
    wlow(n);
    rd(rps_pkg::ADDR_STAT, st(rps_pkg::cause_mrst_sleep, 1'b0, 1'b1));
    @(posedge pclk);
    int_wake <= 1'b1;
    @(posedge pclk);
    int_wake <= 1'b0;
    ww(n);
    chk(32'(n), 32'h1);
    rd(rps_pkg::ADDR_STAT, st(rps_pkg::cause_int_wake, 1'b0, 1'b1));
    sleep_state <= 1'b0;
    $display("end of test: sleep and wake");
    @(posedge pclk);
    brn_low <= 1'b1;
    repeat (4) @(posedge pclk);
    brn_low <= 1'b0;
    wlow(n);
    chk(32'(n >= 500), 32'h1);
    rd(rps_pkg::ADDR_STAT, st(rps_pkg::cause_brown, 1'b1, 1'b1));
    wr(rps_pkg::ADDR_CFG, 32'h09);
    wd_pulse(1'b1);
    wlow(n);
    chk(32'(n >= 2850 && n <= 2890), 32'h1);
    rd(rps_pkg::ADDR_STAT, st(rps_pkg::cause_wdog_wake, 1'b0, 1'b0));
    sleep_state <= 1'b0;
    $display("end of test: brown-out and start-up count");
    wr(4'h2, 32'h7f);
    chk(32'(err), 32'h1);
    rd(4'h1, 32'h0);
    $display("end of test: misaligned access");
    final_report();
  end
endmodule
